// file: rtl/serial_port_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the serial port
// Assumes: Word registers on a plain strobe port, 8-bit data
// Notes:   Definitions only
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH

`define ADDR_SERIAL_CONTROL   4'h0
`define ADDR_SERIAL_BUFFER    4'h1
`define ADDR_SERIAL_STATUS    4'h2
`define ADDR_POWER_CONTROL    4'h3
`define ADDR_BAUD_DIV_LOW     4'h4
`define ADDR_BAUD_DIV_HIGH    4'h5
`define ADDR_BAUD_SOURCE      4'h6

// Serial control fields
`define SC_MODE_HIGH          7
`define SC_MODE_LOW           6
`define SC_RX_ENABLE          4
`define SC_TX_NINTH           3
`define SC_RX_NINTH           2
`define SC_TX_DONE            1
`define SC_RX_DONE            0
// Serial status fields
`define SS_DOUBLE_BUFFER      7
`define SS_FRAMING_ERROR      3
`define SS_BREAK              2
`define SS_OVERRUN            1
`define SS_BREAK_RESET_EN     0
// Power control fields
`define PC_BAUD_DOUBLER       7
`define PC_FE_VIEW            6

`define RESET_BYTE            8'h00
`define BAUD_DIV_RESET        16'h0010

// Fixed rates in CPU clocks per bit, oversample and break counts, boot address
`define SHIFT_DIV             8'd16
`define FIXED_DIV_FAST        8'd16
`define FIXED_DIV_SLOW        8'd32
`define OVERSAMPLE            4'd15
`define BREAK_BITS            4'd11
`define BOOT_ADDRESS_RESET    16'h1f00

`endif

// file: rtl/serial_port_pkg.sv
// Purpose: Types of the serial port
// Assumes: Used with serial_port_regs.svh
// Notes:   Types only
package serial_port_pkg;
  typedef enum logic [1:0] {
    MODE_SHIFT,
    MODE_UART8,
    MODE_UART9_FIXED,
    MODE_UART9_VAR
  } serial_mode_t;

  typedef enum logic [1:0] {
    SRC_TIMER1,
    SRC_BAUD_GEN
  } baud_source_t;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_SEND,
    TX_SHIFT_OUT
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_SHIFT_IN
  } rx_state_t;
endpackage

// file: rtl/baud_tick.sv
// Purpose: Tick generator dividing the CPU clock by a loadable count
// Assumes: Divisor of zero behaves as one
// Notes:   Tick is one cycle long for divisors above one; it stays high every cycle for zero or one
`timescale 1ns/100ps
`default_nettype none
module baud_tick (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        restart_i,
  input  wire logic [15:0] divisor_i,
  output logic             tick_o
);
  logic [15:0] count;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count  <= 16'h0000;
      tick_o <= 1'b0;
    end else if (restart_i) begin
      count  <= 16'h0000;
      tick_o <= 1'b0;
    end else if (count + 16'h0001 >= divisor_i) begin
      count  <= 16'h0000;
      tick_o <= 1'b1;
    end else begin
      count  <= count + 16'h0001;
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: rtl/enhanced_serial_port.sv
// Functional notes
// R1: Shift mode moves 8 bits LSB first on receive pin, clock on transmit pin. Code drives that clock only when transmitting; shift reception leaves it high.
// R2: Shift mode runs at CPU clock divided by sixteen.
// R3: 8-bit mode frame: low start, eight data LSB first, high stop.
// R4: 8-bit mode reception stores the stop bit as received ninth bit.
// R5: 8-bit mode rate comes from timer 1 overflow or baud generator.
// R6: Fixed 9-bit frame: start, eight data, transmit ninth bit, stop.
// R7: 9-bit reception keeps the ninth bit and drops the stop bit.
// R8: Fixed 9-bit rate is CPU clock over 16 or 32 by doubler.
// R9: Variable 9-bit mode equals fixed mode but with variable rate.
// R10: Baud generator divisor is high and low registers joined; timer 1 free.
// R11: Baud generator counts on the CPU clock.
// R12: Timer 1 overflow rate is halved when doubler select is clear.
// R13: Timer 2 overflow is never a rate source.
// R14: Framing error in status; control bit 7 shows it when view select set.
// R15: Software sets mode bits while framing view select is clear.
// R16: Eleven consecutive low bit times on receive report a break.
// R17: With break reset enabled, a break resets device into programming mode.
// R18: Double buffering sends characters back to back with one stop bit.
// R19: Double buffer enable clear gives the single-buffered transmitter.
// R20: Software keeps double buffering off in shift mode.
// R21: Double buffered transmit flag rises when the buffer can take data.
// R22: Single buffered: software holds ninth bit until transmit flag.
// R23: Double buffered: ninth bit is captured together with the buffer data.
// R24: After a break reset, fetching starts at the boot address.
// R25: Receiver finds falling start edge and samples bit centres at 16x.
//
// Purpose: Enhanced asynchronous serial port with register port
// Assumes: Timer 1 overflow arrives as a one-cycle pulse on clock_i
// Notes:   Read data stand one cycle after the read strobe
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_regs.svh"
module enhanced_serial_port (
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        write_i,
  input  wire logic        read_i,
  output logic      [7:0]  rdata_o,
  input  wire logic        timer1_overflow_i,
  input  wire logic        rxd_i,
  output logic             rxd_o,
  output logic             rxd_oe_o,
  output logic             txd_o,
  output logic             tx_irq_o,
  output logic             rx_irq_o,
  output logic             break_reset_o,
  output logic             in_system_programming_mode_o,
  output logic      [15:0] fetch_address_o
);
  import serial_port_pkg::*;

  logic [1:0] rst_sync;
  logic       rst_n;
  logic       rx_meta;
  logic       rx_pin;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_meta <= 1'b1;
      rx_pin  <= 1'b1;
    end else begin
      rx_meta <= rxd_i;
      rx_pin  <= rx_meta;
    end
  end

  // Registers
  logic [1:0]  mode_bits;
  logic        rx_enable;
  logic        tx_ninth;
  logic        rx_ninth;
  logic        tx_done;
  logic        rx_done;
  logic        double_buffer;
  logic        framing_error;
  logic        break_seen;
  logic        overrun;
  logic        break_reset_en;
  logic        baud_doubler_select;
  logic        framing_error_view_select;
  logic [7:0]  baud_divisor_low;
  logic [7:0]  baud_divisor_high;
  logic        baud_source;
  logic [7:0]  rx_data;
  serial_mode_t mode;
  assign mode = serial_mode_t'(mode_bits);

  logic wr_ctrl;
  logic wr_buf;
  logic wr_stat;
  assign wr_ctrl = write_i && addr_i == `ADDR_SERIAL_CONTROL;
  assign wr_buf  = write_i && addr_i == `ADDR_SERIAL_BUFFER;
  assign wr_stat = write_i && addr_i == `ADDR_SERIAL_STATUS;

  // Events from transmit and receive paths
  logic tx_flag_set;
  logic rx_flag_set;
  logic rx_ninth_set;
  logic rx_ninth_val;
  logic fe_set;
  logic break_set;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      baud_doubler_select       <= 1'b0;
      framing_error_view_select <= 1'b0;
      {baud_divisor_high, baud_divisor_low} <= `BAUD_DIV_RESET;
      baud_source               <= 1'b0;
    end else if (write_i) begin
      case (addr_i)
        `ADDR_POWER_CONTROL: begin
          baud_doubler_select       <= wdata_i[`PC_BAUD_DOUBLER];
          framing_error_view_select <= wdata_i[`PC_FE_VIEW];
        end
        `ADDR_BAUD_DIV_LOW:  baud_divisor_low  <= wdata_i;
        `ADDR_BAUD_DIV_HIGH: baud_divisor_high <= wdata_i;
        // R13 no timer 2
        `ADDR_BAUD_SOURCE:   baud_source       <= wdata_i[0];
        default: ;
      endcase
    end
  end

  // R14 framing view bit 7
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_bits <= 2'b00;
      rx_enable <= 1'b0;
      tx_ninth  <= 1'b0;
    end else if (wr_ctrl) begin
      if (!framing_error_view_select) begin
        mode_bits[1] <= wdata_i[`SC_MODE_HIGH];
      end
      mode_bits[0] <= wdata_i[`SC_MODE_LOW];
      rx_enable    <= wdata_i[`SC_RX_ENABLE];
      tx_ninth     <= wdata_i[`SC_TX_NINTH];
    end
  end

  // Sticky flags, set wins over clear
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_done       <= 1'b0;
      rx_done       <= 1'b0;
      rx_ninth      <= 1'b0;
      framing_error <= 1'b0;
      overrun       <= 1'b0;
    end else begin
      if (tx_flag_set) begin
        tx_done <= 1'b1;
      end else if (wr_ctrl) begin
        tx_done <= wdata_i[`SC_TX_DONE];
      end
      if (rx_flag_set) begin
        rx_done <= 1'b1;
      end else if (wr_ctrl) begin
        rx_done <= wdata_i[`SC_RX_DONE];
      end
      if (rx_ninth_set) begin
        rx_ninth <= rx_ninth_val;
      end else if (wr_ctrl) begin
        rx_ninth <= wdata_i[`SC_RX_NINTH];
      end
      // R14 framing error flag
      if (fe_set) begin
        framing_error <= 1'b1;
      end else if (wr_stat && !wdata_i[`SS_FRAMING_ERROR]) begin
        framing_error <= 1'b0;
      end else if (wr_ctrl && framing_error_view_select && !wdata_i[`SC_MODE_HIGH]) begin
        framing_error <= 1'b0;
      end
      if (rx_flag_set && rx_done) begin
        overrun <= 1'b1;
      end else if (wr_stat && !wdata_i[`SS_OVERRUN]) begin
        overrun <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      double_buffer  <= 1'b0;
      break_reset_en <= 1'b0;
      break_seen     <= 1'b0;
    end else begin
      if (wr_stat) begin
        double_buffer  <= wdata_i[`SS_DOUBLE_BUFFER];
        break_reset_en <= wdata_i[`SS_BREAK_RESET_EN];
      end
      // R16 break flag
      if (break_set) begin
        break_seen <= 1'b1;
      end else if (wr_stat && !wdata_i[`SS_BREAK]) begin
        break_seen <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= `RESET_BYTE;
    end else if (read_i) begin
      case (addr_i)
        `ADDR_SERIAL_CONTROL: rdata_o <= {framing_error_view_select ? framing_error : mode_bits[1],
                                          mode_bits[0], 1'b0, rx_enable, tx_ninth, rx_ninth,
                                          tx_done, rx_done};
        `ADDR_SERIAL_BUFFER:  rdata_o <= rx_data;
        `ADDR_SERIAL_STATUS:  rdata_o <= {double_buffer, 3'b000, framing_error, break_seen,
                                          overrun, break_reset_en};
        `ADDR_POWER_CONTROL:  rdata_o <= {baud_doubler_select, framing_error_view_select, 6'h00};
        `ADDR_BAUD_DIV_LOW:   rdata_o <= baud_divisor_low;
        `ADDR_BAUD_DIV_HIGH:  rdata_o <= baud_divisor_high;
        `ADDR_BAUD_SOURCE:    rdata_o <= {7'h00, baud_source};
        default:              rdata_o <= `RESET_BYTE;
      endcase
    end else begin
      rdata_o <= `RESET_BYTE;
    end
  end

  // Rate generation: one oversample tick per sixteenth bit in 8-bit and variable 9-bit modes
  logic gen_tick;
  logic t1_half;
  logic t1_tick;
  logic var_tick;

  // R10 joined divisor
  // R11 counts CPU clock
  baud_tick u_baud_gen (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n),
    .restart_i (wr_stat),
    .divisor_i ({baud_divisor_high, baud_divisor_low}),
    .tick_o    (gen_tick)
  );

  // R12 timer 1 halving
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      t1_half <= 1'b0;
    end else if (timer1_overflow_i) begin
      t1_half <= ~t1_half;
    end
  end
  assign t1_tick = timer1_overflow_i && (baud_doubler_select || t1_half);
  // R5 variable rate
  assign var_tick = baud_source ? gen_tick : t1_tick;

  // R9 variable 9-bit rate
  logic os_tick;
  assign os_tick = (mode == MODE_UART9_FIXED) ? 1'b1 : var_tick;

  // Fixed 9-bit and shift modes count bits by cycles, 8-bit and variable 9-bit modes by sixteen oversample ticks
  logic [7:0] bit_len;
  always_comb begin
    case (mode)
      // R2 fixed shift rate
      MODE_SHIFT:       bit_len = `SHIFT_DIV;
      // R8 fixed rate select
      MODE_UART9_FIXED: bit_len = baud_doubler_select ? `FIXED_DIV_FAST : `FIXED_DIV_SLOW;
      default:          bit_len = 8'd16;
    endcase
  end
  logic step;
  assign step = (mode == MODE_SHIFT || mode == MODE_UART9_FIXED) ? 1'b1 : os_tick;

  // Transmitter
  tx_state_t  tx_state;
  logic [7:0] tx_count;
  logic [3:0] tx_bit;
  logic [10:0] tx_shift;
  logic [7:0] hold_data;
  logic       hold_ninth;
  logic       hold_full;
  logic [3:0] frame_len;
  assign frame_len = (mode == MODE_UART8) ? 4'd10 : 4'd11;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      hold_full  <= 1'b0;
      hold_data  <= `RESET_BYTE;
      hold_ninth <= 1'b0;
    end else if (wr_buf) begin
      hold_full  <= 1'b1;
      hold_data  <= wdata_i;
      // R23 ninth bit captured
      hold_ninth <= tx_ninth;
    end else if (tx_state == TX_IDLE || (tx_state == TX_SEND && double_buffer
                 && tx_bit == frame_len - 4'd1 && tx_count == bit_len - 8'd1 && step)) begin
      hold_full <= 1'b0;
    end
  end

  logic tx_end;
  assign tx_end = step && tx_count == bit_len - 8'd1;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_state    <= TX_IDLE;
      tx_count    <= 8'd0;
      tx_bit      <= 4'd0;
      tx_shift    <= 11'h7ff;
      txd_o       <= 1'b1;
      rxd_o       <= 1'b1;
      rxd_oe_o    <= 1'b0;
      tx_flag_set <= 1'b0;
    end else begin
      tx_flag_set <= 1'b0;
      case (tx_state)
        TX_IDLE: begin
          txd_o    <= 1'b1;
          rxd_oe_o <= 1'b0;
          tx_count <= 8'd0;
          tx_bit   <= 4'd0;
          if (hold_full && mode == MODE_SHIFT) begin
            tx_shift <= {3'b111, hold_data};
            tx_state <= TX_SHIFT_OUT;
          end else if (hold_full) begin
            // R3 start data stop
            // R6 ninth bit frame
            tx_shift <= (mode == MODE_UART8) ? {2'b11, hold_data, 1'b0}
                                             : {1'b1, hold_ninth, hold_data, 1'b0};
            tx_state <= TX_SEND;
            // R21 buffer free flag
            tx_flag_set <= double_buffer;
          end
        end
        TX_SEND: begin
          txd_o <= tx_shift[0];
          if (step) begin
            tx_count <= tx_count + 8'd1;
          end
          if (tx_end) begin
            tx_count <= 8'd0;
            tx_shift <= {1'b1, tx_shift[10:1]};
            tx_bit   <= tx_bit + 4'd1;
            if (tx_bit == frame_len - 4'd1) begin
              // R18 back to back
              if (double_buffer && hold_full) begin
                tx_shift <= (mode == MODE_UART8) ? {2'b11, hold_data, 1'b0}
                                                 : {1'b1, hold_ninth, hold_data, 1'b0};
                tx_bit      <= 4'd0;
                tx_flag_set <= 1'b1;
              end else begin
                tx_state    <= TX_IDLE;
                // R19 single buffer flag
                tx_flag_set <= !double_buffer;
              end
            end
          end
        end
        TX_SHIFT_OUT: begin
          // R1 shift clock out
          rxd_oe_o <= 1'b1;
          rxd_o    <= tx_shift[0];
          tx_count <= tx_count + 8'd1;
          txd_o    <= tx_count < 8'd8 ? 1'b0 : 1'b1;
          if (tx_end) begin
            tx_count <= 8'd0;
            tx_shift <= {1'b1, tx_shift[10:1]};
            tx_bit   <= tx_bit + 4'd1;
            if (tx_bit == 4'd7) begin
              tx_state    <= TX_IDLE;
              tx_flag_set <= 1'b1;
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // Receiver
  rx_state_t  rx_state;
  logic [7:0] rx_count;
  logic [3:0] rx_bit;
  logic [8:0] rx_shift;
  logic       rx_prev;
  logic [7:0] half_len;
  assign half_len = {1'b0, bit_len[7:1]};

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_state     <= RX_IDLE;
      rx_count     <= 8'd0;
      rx_bit       <= 4'd0;
      rx_shift     <= 9'h000;
      rx_prev      <= 1'b1;
      rx_data      <= `RESET_BYTE;
      rx_flag_set  <= 1'b0;
      rx_ninth_set <= 1'b0;
      rx_ninth_val <= 1'b0;
      fe_set       <= 1'b0;
    end else begin
      rx_prev      <= rx_pin;
      rx_flag_set  <= 1'b0;
      rx_ninth_set <= 1'b0;
      fe_set       <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          rx_count <= 8'd0;
          rx_bit   <= 4'd0;
          if (rx_enable && mode == MODE_SHIFT && !rx_done && tx_state == TX_IDLE) begin
            rx_state <= RX_SHIFT_IN;
          // R25 falling start edge
          end else if (rx_enable && mode != MODE_SHIFT && rx_prev && !rx_pin) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (step) begin
            rx_count <= rx_count + 8'd1;
          end
          if (step && rx_count == half_len - 8'd1) begin
            rx_count <= 8'd0;
            rx_state <= rx_pin ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (step) begin
            rx_count <= rx_count + 8'd1;
          end
          // R25 centre sample
          if (step && rx_count == bit_len - 8'd1) begin
            rx_count <= 8'd0;
            rx_bit   <= rx_bit + 4'd1;
            if (rx_bit == frame_len - 4'd2) begin
              rx_state     <= RX_IDLE;
              rx_data      <= (mode == MODE_UART8) ? rx_shift[8:1] : rx_shift[7:0];
              rx_flag_set  <= 1'b1;
              rx_ninth_set <= 1'b1;
              // R4 stop as ninth
              // R7 ninth kept, stop dropped
              rx_ninth_val <= (mode == MODE_UART8) ? rx_pin : rx_shift[8];
              fe_set       <= !rx_pin;
            end else begin
              rx_shift <= {rx_pin, rx_shift[8:1]};
            end
          end
        end
        RX_SHIFT_IN: begin
          rx_count <= rx_count + 8'd1;
          if (rx_count == bit_len - 8'd1) begin
            rx_count <= 8'd0;
            rx_bit   <= rx_bit + 4'd1;
            rx_shift <= {rx_pin, rx_shift[8:1]};
            if (rx_bit == 4'd7) begin
              rx_state    <= RX_IDLE;
              rx_data     <= {rx_pin, rx_shift[8:2]};
              rx_flag_set <= 1'b1;
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // R16 eleven low bits
  logic [7:0] low_count;
  logic [3:0] low_bits;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      low_count <= 8'd0;
      low_bits  <= 4'd0;
      break_set <= 1'b0;
    end else begin
      break_set <= 1'b0;
      if (rx_pin || mode == MODE_SHIFT) begin
        low_count <= 8'd0;
        low_bits  <= 4'd0;
      end else if (step && low_bits != `BREAK_BITS) begin
        low_count <= low_count + 8'd1;
        if (low_count == bit_len - 8'd1) begin
          low_count <= 8'd0;
          low_bits  <= low_bits + 4'd1;
          break_set <= low_bits == `BREAK_BITS - 4'd1;
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_irq_o <= 1'b0;
      rx_irq_o <= 1'b0;
    end else begin
      tx_irq_o <= tx_done;
      rx_irq_o <= rx_done;
    end
  end

  // R17 break reset request
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      break_reset_o <= 1'b0;
    end else begin
      break_reset_o <= break_set && break_reset_en;
    end
  end

  // Latched across the device reset that the break requests; only the pin reset clears it
  // R24 boot address fetch
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      in_system_programming_mode_o <= 1'b0;
      fetch_address_o              <= 16'h0000;
    end else if (break_set && break_reset_en) begin
      in_system_programming_mode_o <= 1'b1;
      fetch_address_o              <= `BOOT_ADDRESS_RESET;
    end
  end
endmodule
`default_nettype wire

// file: bench/serial_port_checker.sv
// Purpose: Port assertions for the serial port
// Assumes: Bound to enhanced_serial_port
// Notes:   Transmit and receive flags clear only by control writes
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_regs.svh"
module serial_port_checker (
  input wire logic        clock_i,
  input wire logic        rstn_i,
  input wire logic [3:0]  addr_i,
  input wire logic        write_i,
  input wire logic        read_i,
  input wire logic [7:0]  rdata_o,
  input wire logic        txd_o,
  input wire logic        tx_irq_o,
  input wire logic        rx_irq_o,
  input wire logic        break_reset_o,
  input wire logic        in_system_programming_mode_o,
  input wire logic [15:0] fetch_address_o
);
  logic wr_ctrl;
  logic in_system_programming_mode;
  assign wr_ctrl = write_i && addr_i == `ADDR_SERIAL_CONTROL;
  assign in_system_programming_mode = in_system_programming_mode_o;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  a_rdata_idle: assert property (!$past(read_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside answer");
  a_txd_low_min: assert property ($fell(txd_o) |-> !txd_o [*8])
    else $error("serial output low too briefly");
  a_break_one_cycle: assert property (break_reset_o |=> !break_reset_o)
    else $error("break reset pulse too long");
  a_isp_sticky: assert property (in_system_programming_mode |=> in_system_programming_mode)
    else $error("programming mode dropped");
  a_isp_cause: assert property ($rose(in_system_programming_mode) |-> $past(break_reset_o) || break_reset_o)
    else $error("programming mode without break");
  a_boot_fetch: assert property (break_reset_o |-> ##[0:2] fetch_address_o == `BOOT_ADDRESS_RESET)
    else $error("fetch not at boot address");
  a_tx_flag_clear: assert property ($fell(tx_irq_o) && !in_system_programming_mode |->
    $past(wr_ctrl, 2) || $past(wr_ctrl, 3))
    else $error("transmit flag fell without write");
  a_rx_flag_clear: assert property ($fell(rx_irq_o) && !in_system_programming_mode |->
    $past(wr_ctrl, 2) || $past(wr_ctrl, 3))
    else $error("receive flag fell without write");
endmodule
bind enhanced_serial_port serial_port_checker chk_u (.clock_i, .rstn_i, .addr_i, .write_i,
  .read_i, .rdata_o, .txd_o, .tx_irq_o, .rx_irq_o, .break_reset_o,
  .in_system_programming_mode_o, .fetch_address_o);
`default_nettype wire

// file: bench/remote_serial.sv
// Purpose: Remote serial device on the port pins
// Assumes: Bit time in cycles set by the bench
// Notes:   Line is driven high at rest
`timescale 1ns/100ps
`default_nettype none
module remote_serial (
  input  wire logic clock_i,
  input  wire logic txd_i,
  output logic      rxd_o
);
  int bit_cycles = 16;
  int idle;
  logic [10:0] got;
  initial rxd_o = 1'b1;
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rxd_o <= f[i];
      repeat (bit_cycles) @(posedge clock_i);
    end
    rxd_o <= 1'b1;
  endtask
  task automatic take(input int n);
    idle = 0;
    got = '1;
    while (txd_i && idle < 4000) begin
      @(posedge clock_i);
      idle++;
    end
    repeat (bit_cycles / 2) @(posedge clock_i);
    for (int i = 0; i < n; i++) begin
      got[i] = txd_i;
      if (i < n - 1) repeat (bit_cycles) @(posedge clock_i);
    end
  endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Purpose: Self-checking bench for the serial port
// Assumes: Remote serial model on the pins
// Notes:   Register rows first, then frames and breaks
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct { logic [3:0] a; logic [7:0] d; logic [7:0] e; } row_t;
  logic clock_i = 0, rstn_i = 0, write_i = 0, read_i = 0, timer1_overflow_i = 0, t1_en = 0;
  logic [3:0] addr_i = 0;
  logic [7:0] wdata_i = 0, rdata_o, seen, bits;
  logic rxd_o, rxd_oe_o, txd_o, tx_irq_o, rx_irq_o, break_reset_o, peer_rxd, rxd_prev;
  logic in_system_programming_mode_o;
  logic [15:0] fetch_address_o;
  logic [10:0] first;
  int num_errors = 0, tests_run = 0, cyc = 0;
  time t0;
  row_t rows[6] = '{'{4'h4, 8'h55, 8'h55}, '{4'h5, 8'ha5, 8'ha5}, '{4'h7, 8'hff, 8'h00},
    '{4'h6, 8'h01, 8'h01}, '{4'h3, 8'hc0, 8'hc0}, '{4'h0, 8'h80, 8'h00}};
  wire logic rxd_i = rxd_oe_o ? rxd_o : peer_rxd;
  enhanced_serial_port dut_u (.clock_i, .rstn_i, .addr_i, .wdata_i, .write_i, .read_i,
    .rdata_o, .timer1_overflow_i, .rxd_i, .rxd_o, .rxd_oe_o, .txd_o, .tx_irq_o, .rx_irq_o,
    .break_reset_o, .in_system_programming_mode_o, .fetch_address_o);
  remote_serial peer_u (.clock_i, .txd_i(txd_o), .rxd_o(peer_rxd));
  always #5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    timer1_overflow_i <= t1_en & ~timer1_overflow_i;
    rxd_prev <= rxd_o;
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    write_i <= 1'b1;
    @(posedge clock_i);
    write_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock_i);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge clock_i);
    read_i <= 1'b0;
    @(posedge clock_i);
    v = rdata_o;
  endtask
  task automatic tx_frame(input logic [7:0] d, input int nb, input int bc, input logic [10:0] e);
    peer_u.bit_cycles = bc;
    wr(4'h1, d);
    peer_u.take(nb);
    check("tx frame", peer_u.got, e);
    repeat (bc) @(posedge clock_i);
    check("tx flag", tx_irq_o, 1'b1);
  endtask
  task automatic rx_frame(input logic [10:0] f, input int nb, input logic [7:0] d, c);
    peer_u.bit_cycles = 16;
    peer_u.send(f, nb);
    repeat (4) @(posedge clock_i);
    rd(4'h1, seen);
    check("rx data", seen, d);
    check("rx flag", rx_irq_o, 1'b1);
    rd(4'h0, seen);
    check("rx ninth", seen & 8'h05, c);
  endtask
  task automatic summarize;
    if (num_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    check("fetch", fetch_address_o, 16'h0000);
    check("txd idle", txd_o, 1'b1);
    rd(4'h4, seen);
    check("div low", seen, 8'h10);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, seen);
      check("reg", seen, rows[i].e);
    end
    wr(4'h3, 8'h80);
    for (int bc = 16; bc <= 32; bc += 16) begin
      wr(4'h0, 8'h88);
      tx_frame(8'ha5, 11, bc, {2'b11, 8'ha5, 1'b0});
      wr(4'h3, 8'h00);
    end
    wr(4'h6, 8'h00);
    wr(4'h0, 8'hc8);
    t1_en <= 1'b1;
    tx_frame(8'h3c, 11, 64, {2'b11, 8'h3c, 1'b0});
    wr(4'h6, 8'h01);
    wr(4'h4, 8'h01);
    wr(4'h5, 8'h00);
    wr(4'h0, 8'h50);
    rx_frame({1'b1, 8'h96, 1'b0}, 10, 8'h96, 8'h05);
    wr(4'h3, 8'h80);
    wr(4'h0, 8'h90);
    rx_frame({2'b10, 8'h3c, 1'b0}, 11, 8'h3c, 8'h01);
    wr(4'h2, 8'h80);
    wr(4'h0, 8'h40);
    fork
      begin
        peer_u.take(10);
        first = peer_u.got;
        peer_u.take(10);
      end
      begin
        wr(4'h1, 8'h81);
        repeat (30) @(posedge clock_i);
        check("early flag", tx_irq_o, 1'b1);
        wr(4'h1, 8'h7e);
      end
    join
    check("first", first, {2'b11, 8'h81, 1'b0});
    check("second", peer_u.got, {2'b11, 8'h7e, 1'b0});
    check("gap", 16'(peer_u.idle <= 10), 16'h0001);
    repeat (20) @(posedge clock_i);
    wr(4'h2, 8'h00);
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h6a);
    for (int i = 0; i < 8; i++) begin
      @(posedge txd_o);
      #1;
      bits[i] = rxd_prev;
      if (i == 1) check("shift period", 16'($time - t0), 16'd160);
      t0 = $time;
    end
    check("rx drive", rxd_oe_o, 1'b1);
    check("shift data", bits, 8'h6a);
    repeat (20) @(posedge clock_i);
    wr(4'h0, 8'h50);
    peer_u.send(12'h000, 12);
    rd(4'h2, seen);
    check("break", seen & 8'h0c, 8'h0c);
    wr(4'h3, 8'h40);
    rd(4'h0, seen);
    check("fe view", seen[7], 1'b1);
    wr(4'h2, 8'h01);
    peer_u.send(12'h000, 12);
    repeat (8) @(posedge clock_i);
    check("isp", in_system_programming_mode_o, 1'b1);
    check("boot", fetch_address_o, 16'h1f00);
    summarize();
  end
endmodule
`default_nettype wire
